// ===== core/lfspc_core.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// R1 - Auto re-enable prior level after overheat ends
// R2 - Bit 7 selects ceramic or electrolytic compensation
// R3 - Status registers are read only
// R4 - Status bits 0,1 show live channel overload
// R5 - Bit 6 overheat flag with hysteresis
// R6 - Bit 7 shows input supply low
// R7 - Status clear at reset; other bits reserved
// R8 - Shorted output cycles 900 ms off, 90 ms on
// R9 - Tone 22 kHz at 50 percent duty
// R10 - Ramp 4/6 ms start, 1.5 ms range change
// R11 - Latch mode clears level selects on overheat
// R12 - Pulsed limiting per channel when bit clear
// R13 - Status reads have no side effects
module lfspc_core #(
   parameter longint OFF_CYCLES  = lfspc_pkg::OFF_CYC,    // Pulsed limit off time
   parameter longint ON_CYCLES   = lfspc_pkg::ON_CYC,     // Pulsed limit on time
   parameter longint R13_CYCLES  = lfspc_pkg::RAMP13_CYC, // Start ramp to 13 V
   parameter longint R18_CYCLES  = lfspc_pkg::RAMP18_CYC, // Start ramp to 18 V
   parameter longint STEP_CYCLES = lfspc_pkg::STEP_CYC    // Range change time
) (
   input  wire logic       clk_in,             // 250 MHz clock
   input  wire logic       sys_rst_in,         // Async reset, high
   input  wire logic [7:0] reg_addr_in,        // Register address
   input  wire logic       reg_wr_in,          // Write strobe
   input  wire logic [7:0] reg_wdata_in,       // Write data
   input  wire logic       reg_rd_in,          // Read strobe
   input  wire logic [3:0] level_sel_a_in,     // Channel A level select
   input  wire logic [3:0] level_sel_b_in,     // Channel B level select
   input  wire logic       pulsed_limit_off_a_in, // Channel A pulsed limit off
   input  wire logic       pulsed_limit_off_b_in, // Channel B pulsed limit off
   input  wire logic       tone_on_in,         // Tone enable
   input  wire logic       tone_source_mode_in,// External tone source
   input  wire logic       tone_control_input_in, // Tone control pin
   input  wire logic       overcur_a_in,       // Channel A current above limit
   input  wire logic       overcur_b_in,       // Channel B current above limit
   input  wire logic       temp_hi_in,         // Junction above 150 C
   input  wire logic       temp_ok_in,         // Junction below 135 C
   input  wire logic       low_supply_detect_in, // Supply below threshold
   output logic [7:0]      reg_rdata_out,      // Read data
   output logic            level_clear_out,    // Pulse: clear level selects
   output logic            out_en_a_out,       // Channel A output enable
   output logic            out_en_b_out,       // Channel B output enable
   output logic            cap_ceramic_out,    // Low ESR compensation
   output logic            tone_out,           // Tone waveform
   output logic            ramp_busy_a_out,    // Channel A ramping
   output logic            ramp_busy_b_out     // Channel B ramping
);
   // ----------------------------------------------
   // Input synchronisers
   // ----------------------------------------------
   localparam int NS = 6;
   logic [NS-1:0] raw_w, s1_q, s2_q;
   assign raw_w = {low_supply_detect_in, temp_ok_in, temp_hi_in, overcur_b_in, overcur_a_in,
                   tone_control_input_in};
   // Two stages before any logic reads the tone control, overload, temperature or supply pins
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         s1_q <= '0;
         s2_q <= '0;
      end else begin
         s1_q <= raw_w;
         s2_q <= s1_q;
      end
   end
   wire tctl_w = s2_q[0];
   wire [1:0] ovl_w = s2_q[2:1];
   wire hot_w = s2_q[3];
   wire cool_w = s2_q[4];
   wire low_w = s2_q[5];

   // ----------------------------------------------
   // Registers and status
   // ----------------------------------------------
   logic [7:0] prot_q;
   logic       heat_q;
   logic       heat_d;
   logic [7:0] status_w;
   wire wr_prot_w = reg_wr_in && (reg_addr_in == lfspc_pkg::ADDR_PROT_CONFIG);
   // Writes to status addresses fall through and are ignored
   assign heat_d = hot_w ? 1'b1 : (cool_w ? 1'b0 : heat_q); // R5
   assign status_w = {low_w, heat_q, 4'h0, ovl_w}; // R4 R6 R7
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         prot_q <= lfspc_pkg::PROT_CONFIG_RST;
         heat_q <= 1'b0; // R7
      end else begin
         heat_q <= heat_d;
         if (wr_prot_w)
            prot_q <= reg_wdata_in & lfspc_pkg::PROT_WR_MASK;
      end
   end
   // Read mux; reading changes no state
   wire [7:0] rd_w = (reg_addr_in == lfspc_pkg::ADDR_FAULT_STATUS) ? status_w :  // R3 R13
                     (reg_addr_in == lfspc_pkg::ADDR_PROT_CONFIG) ? prot_q :
                     lfspc_pkg::STATUS_RST;
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in)
         reg_rdata_out <= 8'h00;
      else if (reg_rd_in)
         reg_rdata_out <= rd_w;
   end

   // ----------------------------------------------
   // Overheat handling
   // ----------------------------------------------
   wire latch_w = prot_q[lfspc_pkg::BIT_HEAT_LATCH];
   wire heat_rise_w = heat_d && !heat_q;
   // Latched mode asks the selector to clear; auto mode keeps the old levels
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         level_clear_out <= 1'b0;
         cap_ceramic_out <= 1'b0;
      end else begin
         level_clear_out <= heat_rise_w && latch_w; // R11
         cap_ceramic_out <= prot_q[lfspc_pkg::BIT_CAP_TYPE]; // R2
      end
   end

   // ----------------------------------------------
   // Per channel pulsed limit and ramp
   // ----------------------------------------------
   logic [1:0] en_q;
   logic [1:0] busy_q;
   wire [1:0] plo_w = {pulsed_limit_off_b_in, pulsed_limit_off_a_in};
   wire [3:0] sel_w [2];
   assign sel_w[0] = level_sel_a_in;
   assign sel_w[1] = level_sel_b_in;
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ch
         logic [31:0] pc_q;
         logic        poff_q;
         logic [31:0] rc_q;
         logic        on_q;
         logic        hi_q;
         wire sel_on_w = (sel_w[g] != 4'h0);
         wire sel_hi_w = sel_w[g][3];
         // Off/on cycle only while shorted with pulsed limit active
         // A dead output draws no current, so the off phase must not end on a quiet flag
         always_ff @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
               pc_q   <= '0;
               poff_q <= 1'b0;
            end else if (plo_w[g] || (!ovl_w[g] && !poff_q)) begin // R12
               pc_q   <= '0;
               poff_q <= 1'b0;
            end else if (pc_q == 32'(poff_q ? OFF_CYCLES - 1 : ON_CYCLES - 1)) begin // R8
               pc_q   <= '0;
               poff_q <= !poff_q;
            end else begin
               pc_q <= pc_q + 32'd1;
            end
         end
         // Ramp timer: start or range change
         always_ff @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
               rc_q <= '0;
               on_q <= 1'b0;
               hi_q <= 1'b0;
            end else begin
               on_q <= sel_on_w;
               hi_q <= sel_hi_w;
               if (sel_on_w && !on_q)
                  rc_q <= 32'(sel_hi_w ? R18_CYCLES : R13_CYCLES); // R10
               else if (sel_on_w && (sel_hi_w != hi_q))
                  rc_q <= 32'(STEP_CYCLES); // R10
               else if (rc_q != 0)
                  rc_q <= rc_q - 32'd1;
            end
         end
         // Output is disabled during overheat and re-enabled in auto mode once it ends
         always_ff @(posedge clk_in or posedge sys_rst_in) begin
            if (sys_rst_in) begin
               en_q[g]   <= 1'b0;
               busy_q[g] <= 1'b0;
            end else begin
               en_q[g]   <= sel_on_w && !heat_q && !poff_q; // R1
               busy_q[g] <= (rc_q != 0);
            end
         end
      end
   endgenerate
   assign out_en_a_out = en_q[0];
   assign out_en_b_out = en_q[1];
   assign ramp_busy_a_out = busy_q[0];
   assign ramp_busy_b_out = busy_q[1];

   // ----------------------------------------------
   // Tone generator
   // ----------------------------------------------
   logic [15:0] tc_q;
   logic        tone_q;
   wire tone_run_w = tone_on_in && !tone_source_mode_in && tctl_w;
   // Internal mode toggles each half period; external mode passes pin level
   always_ff @(posedge clk_in or posedge sys_rst_in) begin
      if (sys_rst_in) begin
         tc_q   <= '0;
         tone_q <= 1'b0;
      end else if (tone_on_in && tone_source_mode_in) begin
         tc_q   <= '0;
         tone_q <= tctl_w;
      end else if (!tone_run_w) begin
         tc_q   <= '0;
         tone_q <= 1'b0;
      end else if (tc_q == 16'(lfspc_pkg::TONE_HALF - 1)) begin // R9
         tc_q   <= '0;
         tone_q <= !tone_q;
      end else begin
         tc_q <= tc_q + 16'd1;
      end
   end
   assign tone_out = tone_q;

   // ----------------------------------------------
   // Checks
   // ----------------------------------------------
   a_status_reserved: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R7
      reg_rd_in && reg_addr_in == lfspc_pkg::ADDR_FAULT_STATUS |=> reg_rdata_out[5:2] == 4'h0)
      else $error("reserved status bits set");
   a_heat_hold: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R5
      heat_q && !cool_w |=> heat_q) else $error("overheat flag dropped early");
   a_latch_clear: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R11
      heat_rise_w && latch_w |=> level_clear_out) else $error("latched clear missing");
   a_auto_noclear: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R1
      !latch_w |=> !level_clear_out) else $error("clear in auto mode");
   a_comp_follow: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R2
      wr_prot_w |=> ##1 cap_ceramic_out == $past(reg_wdata_in[7], 2)) else $error("comp bit");
   a_status_ro: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R3
      reg_wr_in && reg_addr_in == lfspc_pkg::ADDR_FAULT_STATUS |=> $stable(prot_q))
      else $error("status write took effect");
   a_read_live: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R4
      reg_rd_in && reg_addr_in == lfspc_pkg::ADDR_FAULT_STATUS |=> reg_rdata_out[1:0] == $past(ovl_w))
      else $error("overload flag mismatch");
   a_no_pulse_off: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R12
      pulsed_limit_off_a_in |=> g_ch[0].pc_q == 0) else $error("pulse ran while off");
   a_tone_idle: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R9
      !tone_on_in |=> !tone_q) else $error("tone while disabled");
   a_low_flag: assert property (@(posedge clk_in) disable iff (sys_rst_in) // R6
      reg_rd_in && reg_addr_in == lfspc_pkg::ADDR_FAULT_STATUS |=> reg_rdata_out[7] == $past(low_w))
      else $error("low flag");
endmodule
`default_nettype wire

// ===== core/lfspc_pkg.sv
package lfspc_pkg;
   // --------------------------------------------------
   // Register map
   // --------------------------------------------------
   localparam logic [7:0] ADDR_FAULT_STATUS = 8'h00;
   localparam logic [7:0] ADDR_SPARE_STATUS = 8'h01;
   localparam logic [7:0] ADDR_PROT_CONFIG  = 8'h05;
   localparam logic [7:0] PROT_CONFIG_RST   = 8'h00;
   localparam logic [7:0] STATUS_RST        = 8'h00;
   localparam logic [7:0] PROT_WR_MASK      = 8'hc8;
   // --------------------------------------------------
   // Field positions
   // --------------------------------------------------
   localparam int BIT_OVL_A      = 0;
   localparam int BIT_OVL_B      = 1;
   localparam int BIT_OVERHEAT   = 6;
   localparam int BIT_INPUT_LOW  = 7;
   localparam int BIT_OVL_LATCH  = 3;
   localparam int BIT_HEAT_LATCH = 6;
   localparam int BIT_CAP_TYPE   = 7;
   // --------------------------------------------------
   // Timing
   // --------------------------------------------------
   localparam longint CLK_HZ       = 250000000;
   localparam longint OFF_TIME_MS  = 900;
   localparam longint OFF_CYC      = OFF_TIME_MS * CLK_HZ / 1000;
   localparam longint ON_CYC       = OFF_CYC / 10;
   localparam longint TONE_HZ      = 22000;
   localparam longint TONE_HALF    = CLK_HZ / (2 * TONE_HZ);
   localparam longint RAMP13_US    = 4000;
   localparam longint RAMP18_US    = 6000;
   localparam longint STEP_US      = 1500;
   localparam longint RAMP13_CYC   = RAMP13_US * (CLK_HZ / 1000000);
   localparam longint RAMP18_CYC   = RAMP18_US * (CLK_HZ / 1000000);
   localparam longint STEP_CYC     = STEP_US * (CLK_HZ / 1000000);
endpackage

// ===== sim/lfspc_load_model.sv
`timescale 1ns/1ps
`default_nettype none
// --------------------------------------------------
// Shorted load on each channel output
// --------------------------------------------------
module lfspc_load_model (
   input  wire logic short_a_in,    // Channel A shorted
   input  wire logic short_b_in,    // Channel B shorted
   input  wire logic out_en_a_in,   // Channel A powered
   input  wire logic out_en_b_in,   // Channel B powered
   output logic      overcur_a_out, // Channel A over limit
   output logic      overcur_b_out  // Channel B over limit
);
   // A short only draws over-limit current while powered, so the off phase really idles
   assign overcur_a_out = short_a_in & out_en_a_in;
   assign overcur_b_out = short_b_in & out_en_b_in;
endmodule
`default_nettype wire

// ===== sim/lnb_fault_status_and_protection_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
module lnb_fault_status_and_protection_ctrl_test;
   localparam int HALF = 250000000 / (2 * 22000);
   logic       clk_in = 1'b0;
   logic       sys_rst_in = 1'b1;
   logic       wr_q = 1'b0;
   logic       rd_q = 1'b0;
   logic [7:0] addr_q = 8'h00;
   logic [7:0] wdata_q = 8'h00;
   logic [3:0] sel_a = 4'h0;
   logic [3:0] sel_b = 4'h0;
   logic       plo_a = 1'b0;
   logic       plo_b = 1'b1;
   logic       t_on = 1'b0;
   logic       t_ctl = 1'b0;
   logic       t_ext = 1'b0;
   logic       t_hi = 1'b0;
   logic       t_ok = 1'b1;
   logic       low_in = 1'b0;
   logic       short_a = 1'b0;
   logic       short_b = 1'b0;
   wire        oc_a, oc_b, clr, en_a, en_b, cap, tone, busy_a, busy_b;
   wire [7:0]  rdata;
   wire [5:0]  mon = {en_b, tone, busy_b, busy_a, en_a, clr};
   int         err_total = 0;
   int         checked = 0;
   int         n;
   // --------------------------------------------------
   // Design and load
   // --------------------------------------------------
   lfspc_core #(.OFF_CYCLES(100), .ON_CYCLES(10), .R13_CYCLES(40), .R18_CYCLES(60), .STEP_CYCLES(15)) lfspc_core_i (
      .clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr_q), .reg_wr_in(wr_q),
      .reg_wdata_in(wdata_q), .reg_rd_in(rd_q), .level_sel_a_in(sel_a), .level_sel_b_in(sel_b),
      .pulsed_limit_off_a_in(plo_a), .pulsed_limit_off_b_in(plo_b), .tone_on_in(t_on),
      .tone_source_mode_in(t_ext), .tone_control_input_in(t_ctl), .overcur_a_in(oc_a),
      .overcur_b_in(oc_b), .temp_hi_in(t_hi), .temp_ok_in(t_ok), .low_supply_detect_in(low_in),
      .reg_rdata_out(rdata), .level_clear_out(clr), .out_en_a_out(en_a), .out_en_b_out(en_b),
      .cap_ceramic_out(cap), .tone_out(tone), .ramp_busy_a_out(busy_a), .ramp_busy_b_out(busy_b));
   lfspc_load_model lfspc_load_model_i (.short_a_in(short_a), .short_b_in(short_b), .out_en_a_in(en_a),
      .out_en_b_in(en_b), .overcur_a_out(oc_a), .overcur_b_out(oc_b));
   // --------------------------------------------------
   // Access and compare tasks
   // --------------------------------------------------
   task automatic close_out;
      if (err_total == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge clk_in);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         err_total++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask
   task automatic near(input int got, input int exp, input int tol);
      checked++;
      if (got < exp - tol || got > exp + tol) begin
         err_total++;
         $display("[FAIL] %0t span %0d expected %0d", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      addr_q = a;
      wdata_q = d;
      wr_q = 1'b1;
      tick(1);
      wr_q = 1'b0;
      tick(1);
   endtask
   // Read data is registered, so it is looked at one and a half cycles after the take edge
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      addr_q = a;
      rd_q = 1'b1;
      tick(1);
      rd_q = 1'b0;
      tick(1);
      chk(rdata, exp);
   endtask
   // Length of the next phase at level lvl of a watched output, bounded both ways
   task automatic span(input int idx, input logic lvl, output int len);
      int w;
      w = 0;
      len = 0;
      while (mon[idx] !== lvl && w < 30000) begin
         tick(1);
         w++;
      end
      while (mon[idx] === lvl && len < 30000) begin
         tick(1);
         len++;
      end
      if (w >= 30000 || len >= 30000) begin
         err_total++;
         $display("[FAIL] %0t wait ran out", $time);
         close_out();
      end
   endtask
   // --------------------------------------------------
   // Clock and scenarios
   // --------------------------------------------------
   initial forever #2 clk_in = ~clk_in;
   initial begin
      tick(8);
      sys_rst_in = 1'b0;
      tick(2);
      rd(8'h00, 8'h00);
      rd(8'h01, 8'h00);
      wr(8'h00, 8'hff);
      wr(8'h01, 8'hff);
      rd(8'h00, 8'h00);
      rd(8'h01, 8'h00);
      wr(8'h05, 8'hff);
      rd(8'h05, 8'hc8);
      chk({7'h00, cap}, 8'h01);
      wr(8'h05, 8'h00);
      tick(3);
      chk({7'h00, cap}, 8'h00);
      low_in = 1'b1;
      t_hi = 1'b1;
      t_ok = 1'b0;
      tick(4);
      rd(8'h00, 8'hc0);
      t_hi = 1'b0;
      tick(4);
      rd(8'h00, 8'hc0);
      rd(8'h00, 8'hc0);
      t_ok = 1'b1;
      low_in = 1'b0;
      tick(4);
      rd(8'h00, 8'h00);
      sel_a = 4'h1;
      span(2, 1'b1, n);
      near(n, 40, 3);
      sel_a = 4'h8;
      span(2, 1'b1, n);
      near(n, 15, 3);
      sel_b = 4'h8;
      span(3, 1'b1, n);
      near(n, 60, 3);
      plo_a = 1'b1;
      short_a = 1'b1;
      short_b = 1'b1;
      tick(6);
      rd(8'h00, 8'h03);
      short_a = 1'b0;
      short_b = 1'b0;
      tick(6);
      rd(8'h00, 8'h00);
      plo_a = 1'b0;
      short_a = 1'b1;
      span(1, 1'b0, n);
      near(n, 100, 4);
      span(1, 1'b1, n);
      near(n, 10, 4);
      short_a = 1'b0;
      plo_a = 1'b1;
      // Channel B pulses on its own
      plo_b = 1'b0;
      short_b = 1'b1;
      span(5, 1'b0, n);
      near(n, 100, 4);
      short_b = 1'b0;
      plo_b = 1'b1;
      tick(120);
      t_hi = 1'b1;
      t_ok = 1'b0;
      tick(6);
      chk({6'h00, en_b, en_a}, 8'h00);
      t_hi = 1'b0;
      t_ok = 1'b1;
      tick(6);
      chk({6'h00, en_b, en_a}, 8'h03);
      wr(8'h05, 8'h40);
      rd(8'h05, 8'h40);
      t_hi = 1'b1;
      t_ok = 1'b0;
      span(0, 1'b1, n);
      near(n, 1, 0);
      // Host answers the clear pulse by dropping its level selects
      sel_a = 4'h0;
      sel_b = 4'h0;
      tick(2);
      chk({7'h00, en_a}, 8'h00);
      t_hi = 1'b0;
      t_ok = 1'b1;
      tick(6);
      chk({7'h00, en_a}, 8'h00);
      sel_a = 4'h1;
      tick(3);
      chk({7'h00, en_a}, 8'h01);
      t_on = 1'b1;
      t_ctl = 1'b1;
      span(4, 1'b1, n);
      span(4, 1'b0, n);
      near(n, HALF, 2);
      span(4, 1'b1, n);
      near(n, HALF, 2);
      // External source mode passes the control pin level
      t_ext = 1'b1;
      t_ctl = 1'b0;
      tick(4);
      chk({7'h00, tone}, 8'h00);
      t_ctl = 1'b1;
      tick(4);
      chk({7'h00, tone}, 8'h01);
      // Mid-run reset with overheat pending
      sys_rst_in = 1'b1;
      t_hi = 1'b1;
      t_ok = 1'b0;
      tick(2);
      chk(rdata, 8'h00);
      chk({7'h00, tone}, 8'h00);
      sys_rst_in = 1'b0;
      rd(8'h00, 8'h00);
      close_out();
   end
endmodule
`default_nettype wire
